// [rtl/apcr_pkg.sv]
/*
 * Package of the audio processor configuration register bank: offsets,
 * reset values, field positions, codes and the register port carrier.
 * Assumes one processing clock shared by the bank and its consumers.
 */
package apcr_pkg;

	// Register offsets on the control port.
	localparam logic [7:0] ADDR_CFG_B = 8'h01;
	localparam logic [7:0] ADDR_CFG_C = 8'h02;
	localparam logic [7:0] ADDR_CFG_D = 8'h03;
	localparam logic [7:0] ADDR_CFG_E = 8'h04;

	// Reset values.
	localparam logic [7:0] RST_CFG_B = 8'h42;
	localparam logic [7:0] RST_CFG_C = 8'h7c;
	localparam logic [7:0] RST_CFG_D = 8'h20;
	localparam logic [7:0] RST_CFG_E = 8'h02;
	localparam logic [7:0] RST_READ = 8'h00;

	// Writable bits; all others hold their reset value.
	localparam logic [7:0] WMASK_CFG_C = 8'h83;
	localparam logic [7:0] WMASK_CFG_E = 8'h7f;

	// Register B fields.
	localparam int B_DSP_BYPASS = 0;
	localparam int B_ZERO_CROSS = 6;
	localparam int B_LIMITER = 7;
	// Register C fields.
	localparam int C_OM_LSB = 0;
	localparam int C_HP_BYPASS = 7;
	// Register D fields.
	localparam int D_BINARY_LSB = 0;
	localparam int D_COS_LSB = 4;
	localparam int D_PS_LINK = 6;
	localparam int D_COEF_LINK = 7;
	// Register E fields.
	localparam int E_MIX = 0;
	localparam int E_VOLUME = 1;
	localparam int E_DEEMPH = 2;
	localparam int E_SAO_LSB = 3;
	localparam int E_FIRST_BIT = 6;

	// Power output mode codes.
	localparam logic [1:0] OM_FIXED_COMP = 2'h0;
	localparam logic [1:0] OM_FULL_POWER = 2'h2;

	// Clock output select codes.
	localparam logic [1:0] COS_DIV4 = 2'h1;
	localparam logic [1:0] COS_DIV8 = 2'h2;
	localparam logic [1:0] COS_DIV16 = 2'h3;

	// Highest legal serial output format code.
	localparam logic [2:0] SAO_MAX = 3'h5;

	// Sample rate classes and their processing clock ratios.
	localparam logic [1:0] RATE_BASE = 2'h0;
	localparam logic [1:0] RATE_DOUBLE = 2'h1;
	localparam logic [11:0] PLL_RATIO_BASE = 12'h800;
	localparam logic [11:0] PLL_RATIO_DOUBLE = 12'h400;
	localparam logic [11:0] PLL_RATIO_QUAD = 12'h200;

	// Control port request from the serial control slave.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} apcr_bus_s;

endpackage : apcr_pkg

// [rtl/apcr_config_regs.sv]
/*
 * Configuration register bank of a multichannel audio processor and the
 * control decisions it drives into the processing chain.
 * Assumes the control slave and the processing chain run on mclk_in.
 */
// What this block does
// - Zero-cross bit set: volume applies at zero crossings; clear: at once.
// - Limiter bit selects anti-clipping (0) or range compression (1).
// - Anti-clip thresholds fixed by gain; compression ones follow volume.
// - Output mode: 00 fixed compensation, 10 full power, others reserved.
// - High-pass bypass bit removes DC blocking filter from the path.
// - Four bits choose binary or three-state PWM per channel pair.
// - Binary mode: B output is the inverse of A output.
// - Clock select divides processing clock by 4, 8 or 16.
// - Processing clock ratio is 2048, 1024 or 512 times sample rate.
// - Post-scale link makes every channel use channel 1 post-scale.
// - Coefficient link makes every channel use channel 1 coefficients.
// - Mix bit with bass management off mixes odd into even channel.
// - Mixing uses bass management scales and follows channel mapping.
// - Volume enable cleared bypasses volume stages and fixed offset.
// - De-emphasis replaces first biquad on all channels.
// - De-emphasis acts only while DSP bypass is clear.
// - Three-bit field selects the serial output format.
// - Format codes 000 to 101: I2S, left, right 16/18/20/24.
// - First-bit control chooses MSB first (0) or LSB first (1).
// - Bass management feeds channel 6 from scale-and-mix block.
`timescale 1ns/1ps
module apcr_config_regs (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire apcr_pkg::apcr_bus_s reg_bus_in,
	output logic [7:0] reg_rdata_out,
	input wire logic bass_mgmt_en_in,
	input wire logic [1:0] rate_class_in,
	input wire logic [7:0] vol_change_req_in,
	input wire logic [7:0] zero_cross_in,
	input wire logic [7:0] pwm_a_in,
	input wire logic [7:0] pwm_b_in,
	output logic [7:0] vol_apply_out,
	output logic limiter_compress_sel_out,
	output logic limiter_thresh_follow_vol_out,
	output logic [1:0] power_out_mode_out,
	output logic highpass_active_out,
	output logic [7:0] pwm_a_out,
	output logic [7:0] pwm_b_out,
	output logic clock_out_pin_out,
	output logic [11:0] pll_ratio_out,
	output logic [23:0] postscale_src_out,
	output logic [23:0] coef_src_out,
	output logic [3:0] mix_into_even_out,
	output logic ch6_from_scale_mix_out,
	output logic volume_active_out,
	output logic deemphasis_active_out,
	output logic [2:0] serial_out_format_out,
	output logic serial_out_first_bit_out
);

	logic [7:0] cfg_b_reg;
	logic [7:0] cfg_c_reg;
	logic [7:0] cfg_d_reg;
	logic [7:0] cfg_e_reg;
	logic [7:0] cfg_c_next;
	logic [7:0] cfg_e_next;
	logic [7:0] vol_pend_reg;
	logic [7:0] vol_want;
	logic [7:0] vol_fire;
	logic [3:0] div_cnt_reg;
	logic [7:0] binary_mask;
	logic [1:0] cos_sel;
	logic clk_div_next;
	logic wr_c;
	logic wr_e;

	// Returns the read value of the register at an offset.
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] b, input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] e);
		case (addr)
			apcr_pkg::ADDR_CFG_B: read_mux = b;
			apcr_pkg::ADDR_CFG_C: read_mux = c;
			apcr_pkg::ADDR_CFG_D: read_mux = d;
			apcr_pkg::ADDR_CFG_E: read_mux = e;
			default: read_mux = apcr_pkg::RST_READ;
		endcase
	endfunction : read_mux

	assign wr_c = reg_bus_in.wr && reg_bus_in.addr == apcr_pkg::ADDR_CFG_C;
	assign wr_e = reg_bus_in.wr && reg_bus_in.addr == apcr_pkg::ADDR_CFG_E;
	assign cos_sel = cfg_d_reg[apcr_pkg::D_COS_LSB +: 2];

	// Next register C value; reserved output modes leave the field as is.
	always_comb begin
		cfg_c_next = cfg_c_reg;
		cfg_c_next[apcr_pkg::C_HP_BYPASS] =
			reg_bus_in.wdata[apcr_pkg::C_HP_BYPASS];
		if (reg_bus_in.wdata[apcr_pkg::C_OM_LSB +: 2] ==
			apcr_pkg::OM_FIXED_COMP ||
			reg_bus_in.wdata[apcr_pkg::C_OM_LSB +: 2] ==
			apcr_pkg::OM_FULL_POWER) begin
			cfg_c_next[apcr_pkg::C_OM_LSB +: 2] =
				reg_bus_in.wdata[apcr_pkg::C_OM_LSB +: 2];
		end
	end

	// Next register E value; undefined format codes leave the field as is.
	always_comb begin
		cfg_e_next = (cfg_e_reg & ~apcr_pkg::WMASK_CFG_E) |
			(reg_bus_in.wdata & apcr_pkg::WMASK_CFG_E);
		if (reg_bus_in.wdata[apcr_pkg::E_SAO_LSB +: 3] > apcr_pkg::SAO_MAX) begin
			cfg_e_next[apcr_pkg::E_SAO_LSB +: 3] =
				cfg_e_reg[apcr_pkg::E_SAO_LSB +: 3];
		end
	end

	// Register writes.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cfg_b_reg <= apcr_pkg::RST_CFG_B;
			cfg_c_reg <= apcr_pkg::RST_CFG_C;
			cfg_d_reg <= apcr_pkg::RST_CFG_D;
			cfg_e_reg <= apcr_pkg::RST_CFG_E;
		end else begin
			if (reg_bus_in.wr && reg_bus_in.addr == apcr_pkg::ADDR_CFG_B) begin
				cfg_b_reg <= reg_bus_in.wdata;
			end
			if (wr_c) begin
				cfg_c_reg <= cfg_c_next;
			end
			if (reg_bus_in.wr && reg_bus_in.addr == apcr_pkg::ADDR_CFG_D) begin
				cfg_d_reg <= reg_bus_in.wdata;
			end
			if (wr_e) begin
				cfg_e_reg <= cfg_e_next;
			end
		end
	end

	// Read data, captured on a read strobe; unmapped offsets read zero.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			reg_rdata_out <= apcr_pkg::RST_READ;
		end else if (reg_bus_in.rd) begin
			reg_rdata_out <= read_mux(reg_bus_in.addr, cfg_b_reg, cfg_c_reg,
				cfg_d_reg, cfg_e_reg);
		end
	end

	assign vol_want = vol_change_req_in | vol_pend_reg;
	assign vol_fire = cfg_b_reg[apcr_pkg::B_ZERO_CROSS] ?
		(vol_want & zero_cross_in) : vol_want;

	// Held volume requests and their one-cycle apply pulses.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			vol_pend_reg <= 8'h00;
			vol_apply_out <= 8'h00;
		end else begin
			vol_pend_reg <= vol_want & ~vol_fire;
			vol_apply_out <= vol_fire;
		end
	end

	// Limiter, output mode, filter and volume controls.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			limiter_compress_sel_out <= 1'b0;
			limiter_thresh_follow_vol_out <= 1'b0;
			power_out_mode_out <= apcr_pkg::OM_FIXED_COMP;
			highpass_active_out <= 1'b1;
			volume_active_out <= 1'b1;
		end else begin
			limiter_compress_sel_out <= cfg_b_reg[apcr_pkg::B_LIMITER];
			limiter_thresh_follow_vol_out <= cfg_b_reg[apcr_pkg::B_LIMITER];
			power_out_mode_out <= cfg_c_reg[apcr_pkg::C_OM_LSB +: 2];
			highpass_active_out <= ~cfg_c_reg[apcr_pkg::C_HP_BYPASS];
			volume_active_out <= cfg_e_reg[apcr_pkg::E_VOLUME];
		end
	end

	// Expands each pair's binary bit over both of its channels.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_chan
			assign binary_mask[gi] = cfg_d_reg[apcr_pkg::D_BINARY_LSB + gi / 2];
		end
	endgenerate

	// PWM outputs; binary pairs drive B as the complement of A.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pwm_a_out <= 8'h00;
			pwm_b_out <= 8'h00;
		end else begin
			pwm_a_out <= pwm_a_in;
			pwm_b_out <= (binary_mask & ~pwm_a_in) | (~binary_mask & pwm_b_in);
		end
	end

	always_comb begin
		case (cos_sel)
			apcr_pkg::COS_DIV4: clk_div_next = div_cnt_reg[1];
			apcr_pkg::COS_DIV8: clk_div_next = div_cnt_reg[2];
			apcr_pkg::COS_DIV16: clk_div_next = div_cnt_reg[3];
			default: clk_div_next = 1'b0;
		endcase
	end

	// Free-running divider of the processing clock and the clock pin.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			div_cnt_reg <= 4'h0;
			clock_out_pin_out <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
			clock_out_pin_out <= clk_div_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pll_ratio_out <= apcr_pkg::PLL_RATIO_BASE;
		end else begin
			case (rate_class_in)
				apcr_pkg::RATE_BASE: pll_ratio_out <= apcr_pkg::PLL_RATIO_BASE;
				apcr_pkg::RATE_DOUBLE: pll_ratio_out <= apcr_pkg::PLL_RATIO_DOUBLE;
				default: pll_ratio_out <= apcr_pkg::PLL_RATIO_QUAD;
			endcase
		end
	end

	// Source channel index, three bits per channel, for scales and biquads.
	generate
		for (gi = 0; gi < 8; gi++) begin : g_link
			always_ff @(posedge mclk_in) begin
				if (srst_in) begin
					postscale_src_out[gi*3 +: 3] <= 3'(gi);
					coef_src_out[gi*3 +: 3] <= 3'(gi);
				end else begin
					postscale_src_out[gi*3 +: 3] <=
						cfg_d_reg[apcr_pkg::D_PS_LINK] ? 3'h0 : 3'(gi);
					coef_src_out[gi*3 +: 3] <=
						cfg_d_reg[apcr_pkg::D_COEF_LINK] ? 3'h0 : 3'(gi);
				end
			end
		end
	endgenerate

	// Mixing, bass management, de-emphasis and serial output format.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			mix_into_even_out <= 4'h0;
			ch6_from_scale_mix_out <= 1'b0;
			deemphasis_active_out <= 1'b0;
			serial_out_format_out <= 3'h0;
			serial_out_first_bit_out <= 1'b0;
		end else begin
			// post-mapping pair mix with bass scales
			mix_into_even_out <= {4{cfg_e_reg[apcr_pkg::E_MIX] &
				~bass_mgmt_en_in}};
			ch6_from_scale_mix_out <= bass_mgmt_en_in;
			deemphasis_active_out <= cfg_e_reg[apcr_pkg::E_DEEMPH] &
				~cfg_b_reg[apcr_pkg::B_DSP_BYPASS];
			serial_out_format_out <= cfg_e_reg[apcr_pkg::E_SAO_LSB +: 3];
			serial_out_first_bit_out <= cfg_e_reg[apcr_pkg::E_FIRST_BIT];
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	// Clock pin pattern at divide by four: two high then two low.
	sequence s_pin_hi;
		clock_out_pin_out || cos_sel != apcr_pkg::COS_DIV4;
	endsequence
	sequence s_pin_lo;
		!clock_out_pin_out || cos_sel != apcr_pkg::COS_DIV4;
	endsequence

	zero_cross_off_a: assert property (
		!cfg_b_reg[apcr_pkg::B_ZERO_CROSS] |=> vol_apply_out == $past(vol_want))
		else $error("volume change not applied at once");
	zero_cross_wait_a: assert property (
		cfg_b_reg[apcr_pkg::B_ZERO_CROSS] && zero_cross_in == 8'h00
		|=> vol_apply_out == 8'h00)
		else $error("volume change applied without zero crossing");
	limiter_mode_a: assert property (
		$changed(cfg_b_reg[apcr_pkg::B_LIMITER])
		|=> limiter_compress_sel_out == $past(cfg_b_reg[apcr_pkg::B_LIMITER]))
		else $error("limiter mode did not follow register");
	out_mode_legal_a: assert property (
		power_out_mode_out[0] == 1'b0)
		else $error("reserved power output mode in use");
	binary_pair_a: assert property (
		##1 ((pwm_b_out ^ ~$past(pwm_a_in)) & $past(binary_mask)) == 8'h00)
		else $error("binary B output is not inverse of A");
	clk_div4_a: assert property (
		(cos_sel == apcr_pkg::COS_DIV4) [*3] ##0
		$rose(clock_out_pin_out) |-> ##1 s_pin_hi ##1 s_pin_lo ##1 s_pin_lo)
		else $error("clock pin not divided by four");
	coef_link_a: assert property (
		cfg_d_reg[apcr_pkg::D_COEF_LINK] |=> coef_src_out == 24'h000000)
		else $error("coefficient link not honoured");
	mix_block_a: assert property (
		bass_mgmt_en_in |=> mix_into_even_out == 4'h0 && ch6_from_scale_mix_out)
		else $error("mixing active with bass management");
	deemph_gate_a: assert property (
		cfg_b_reg[apcr_pkg::B_DSP_BYPASS] |=> !deemphasis_active_out)
		else $error("de-emphasis active under bypass");
	sao_range_a: assert property (
		serial_out_format_out <= apcr_pkg::SAO_MAX)
		else $error("undefined serial output format");
	reserved_bits_a: assert property (
		cfg_c_reg[6:2] == apcr_pkg::RST_CFG_C[6:2] && !cfg_e_reg[7])
		else $error("reserved bit changed");
	read_back_a: assert property (
		reg_bus_in.rd && reg_bus_in.addr == apcr_pkg::ADDR_CFG_D
		|=> reg_rdata_out == $past(cfg_d_reg))
		else $error("register D read mismatch");

endmodule : apcr_config_regs

// [testbench/apcr_config_regs_tb_top.sv]
/*
 * Self-checking bench of the audio configuration register bank, with a
 * behavioural model of the registers and of the outputs they drive.
 * Assumes one 100 MHz clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module apcr_config_regs_tb_top;
	logic mclk_in, srst_in, bass, lim, thr, hpa, ckp, ch6, vola, dema, fb;
	apcr_pkg::apcr_bus_s bus;
	logic [1:0] rate, om;
	logic [7:0] vreq, zc, pa, pb, rdata, vapp, qa, qb;
	logic [11:0] pll;
	logic [23:0] pss, cfs;
	logic [3:0] mix;
	logic [2:0] fmt;
	logic [7:0] mb, mc, md, me;
	int fails, n_tests;

	apcr_config_regs apcr_config_regs_i (.mclk_in(mclk_in),
		.srst_in(srst_in), .reg_bus_in(bus), .reg_rdata_out(rdata),
		.bass_mgmt_en_in(bass), .rate_class_in(rate),
		.vol_change_req_in(vreq), .zero_cross_in(zc), .pwm_a_in(pa),
		.pwm_b_in(pb), .vol_apply_out(vapp), .limiter_compress_sel_out(lim),
		.limiter_thresh_follow_vol_out(thr), .power_out_mode_out(om),
		.highpass_active_out(hpa), .pwm_a_out(qa), .pwm_b_out(qb),
		.clock_out_pin_out(ckp), .pll_ratio_out(pll), .postscale_src_out(pss),
		.coef_src_out(cfs), .mix_into_even_out(mix),
		.ch6_from_scale_mix_out(ch6), .volume_active_out(vola),
		.deemphasis_active_out(dema), .serial_out_format_out(fmt),
		.serial_out_first_bit_out(fb));

	// Free running processing clock.
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick

	// Model write: reserved bits and refused codes keep their old value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge mclk_in);
		bus <= '{default: '0};
		case (a)
			8'h01: mb = d;
			8'h02: mc = {d[7], 5'h1f, (d[0] ? mc[1:0] : d[1:0])};
			8'h03: md = d;
			8'h04: me = {1'b0, d[6], (d[5:3] > 3'h5 ? me[5:3] : d[5:3]), d[2:0]};
			default: ;
		endcase
	endtask : wr

	task automatic rchk(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk_in);
		bus <= '{default: '0};
		#1;
		case (a)
			8'h01: v = mb;
			8'h02: v = mc;
			8'h03: v = md;
			8'h04: v = me;
			default: v = 8'h00;
		endcase
		chk(rdata, v);
	endtask : rchk

	task automatic dchk();
		chk(lim, mb[7]);
		chk(thr, mb[7]);
		chk(om, mc[1:0]);
		chk(hpa, {~mc[7]});
		chk(pss, md[6] ? 24'h0 : 24'hfac688);
		chk(cfs, md[7] ? 24'h0 : 24'hfac688);
		chk(mix, {4{me[0] & ~bass}});
		chk(ch6, bass);
		chk(vola, me[1]);
		chk(dema, {me[2] & ~mb[0]});
		chk(fmt, me[5:3]);
		chk(fb, me[6]);
	endtask : dchk

	// Waits a bounded number of cycles for the expected apply pulse.
	task automatic vw(input logic [7:0] e, input int lim_n);
		int n;
		n = 0;
		#1;
		while (vapp !== e && n < lim_n) begin
			tick(1);
			n++;
		end
		chk(vapp, e);
		tick(1);
		chk(vapp, 8'h00);
	endtask : vw

	task automatic results();
		$display("checks %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// Cuts a hung run short.
	initial begin
		#400us;
		fails++;
		results();
	end

	// Main sequence of tests.
	initial begin
		logic [7:0] a, v, eb;
		int n, hi, lo, ch;
		srst_in = 1'b1;
		bus = '{default: '0};
		{bass, rate, vreq, zc, pa, pb} = '0;
		{mb, mc, md, me} = 32'h427c2002;
		fails = 0;
		n_tests = 0;
		void'($urandom(32'h73c2eb4c));
		repeat (20) @(posedge mclk_in);
		srst_in <= 1'b0;
		tick(2);
		for (int i = 0; i < 7; i++) rchk(i[7:0], v);
		dchk();
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			wr(8'h02, {k[2], 5'h00, k[1:0]});
			wr(8'h04, {2'h0, k[2:0], 3'h0});
			rchk(8'h02, v);
			rchk(8'h04, v);
			dchk();
		end
		repeat (40) begin
			a = 8'($urandom % 6);
			@(posedge mclk_in);
			bass <= 1'($urandom);
			wr(a, 8'($urandom));
			rchk(a, v);
			dchk();
		end
		$display("test registers done");
		for (int r = 0; r < 4; r++) begin
			@(posedge mclk_in);
			rate <= r[1:0];
			tick(2);
			chk(pll, r == 0 ? 12'h800 : (r == 1 ? 12'h400 : 12'h200));
		end
		$display("test ratio done");
		repeat (4) begin
			wr(8'h03, 8'($urandom));
			tick(1);
			repeat (4) begin
				@(posedge mclk_in);
				pa <= 8'($urandom);
				pb <= 8'($urandom);
				tick(1);
				for (int i = 0; i < 8; i++) eb[i] = md[i / 2] ? ~pa[i] : pb[i];
				chk(qa, pa);
				chk(qb, eb);
			end
		end
		$display("test pwm done");
		for (int k = 0; k < 4; k++) begin
			wr(8'h03, 8'(k << 4));
			tick(4);
			n = 0;
			hi = 0;
			lo = 0;
			// Starts from a low phase so that a whole high phase is counted.
			while (ckp === 1'b1 && n < 40) begin
				tick(1);
				n++;
			end
			while (ckp !== 1'b1 && n < 40) begin
				tick(1);
				n++;
			end
			while (ckp === 1'b1 && hi < 40) begin
				tick(1);
				hi++;
			end
			while (ckp !== 1'b1 && lo < 40) begin
				tick(1);
				lo++;
			end
			chk(hi, k == 0 ? 0 : 1 << k);
			chk(lo, k == 0 ? 40 : 1 << k);
		end
		$display("test clock done");
		for (int z = 1; z >= 0; z--) begin
			wr(8'h01, z ? 8'h42 : 8'h02);
			ch = $urandom % 8;
			@(posedge mclk_in);
			vreq <= 8'h01 << ch;
			@(posedge mclk_in);
			vreq <= 8'h00;
			if (z == 1) begin
				repeat (5) begin
					tick(1);
					chk(vapp, 8'h00);
				end
				@(posedge mclk_in);
				zc <= 8'h01 << ch;
				@(posedge mclk_in);
				zc <= 8'h00;
			end
			vw(8'h01 << ch, 3);
		end
		$display("test volume done");
		// Reset in mid-run must bring every register back to its reset value.
		@(posedge mclk_in);
		srst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		srst_in <= 1'b0;
		{mb, mc, md, me} = 32'h427c2002;
		tick(2);
		chk(vapp, 8'h00);
		chk(pll, 12'h200);
		for (int i = 0; i < 7; i++) rchk(i[7:0], v);
		dchk();
		$display("test second reset done");
		results();
	end
endmodule : apcr_config_regs_tb_top
